// File: dv/ocdp_command_port_asserts.sv
// Concurrent checks on the octal DAC serial command port
`timescale 1ns/10ps
module ocdp_command_port_asserts
(
    input wire logic                          CLK_SYS,
    input wire logic                          RSTN,
    input wire logic                          CS_N,
    input wire logic                          LOAD_OUTPUTS_N,
    input wire logic                          DOUT,
    input wire ocdp_pkg::ocdp_codes_t         DAC_CODE,
    input wire logic [ocdp_pkg::CHANNELS-1:0] BUF_EN,
    input wire logic                          POWER_DOWN,
    input wire logic                          PHASE_MODE
);
    logic [3:0] hi_cnt;
    logic [3:0] lo_cnt;
    logic [3:0] ld_cnt;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    // Saturating level counts; outputs may only move a few cycles after select or load
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            hi_cnt <= 4'h0;
            lo_cnt <= 4'h0;
            ld_cnt <= 4'h0;
        end
        else
        begin
            hi_cnt <= CS_N ? hi_cnt + 4'(hi_cnt != 4'hf) : 4'h0;
            lo_cnt <= !CS_N ? lo_cnt + 4'(lo_cnt != 4'hf) : 4'h0;
            ld_cnt <= !LOAD_OUTPUTS_N ? ld_cnt + 4'(ld_cnt != 4'hf) : 4'h0;
        end
    end

    property p_pd; POWER_DOWN == (BUF_EN == 8'h00); endproperty
    property p_rst_codes; $rose(RSTN) |-> DAC_CODE == 64'h0 && BUF_EN == 8'hff; endproperty
    property p_rst_phase; $rose(RSTN) |-> !PHASE_MODE && !DOUT; endproperty
    property p_buf; $changed(BUF_EN) |-> hi_cnt >= 4'h2 && hi_cnt <= 4'h6; endproperty
    property p_phase; $changed(PHASE_MODE) |-> hi_cnt >= 4'h2 && hi_cnt <= 4'h6; endproperty
    property p_dac;
        $changed(DAC_CODE) |-> (hi_cnt >= 4'h2 && hi_cnt <= 4'h6) || ld_cnt >= 4'h2;
    endproperty
    property p_dout_hold; hi_cnt >= 4'h8 |-> $stable(DOUT); endproperty
    property p_frame_hold; lo_cnt >= 4'h4 |-> $stable(BUF_EN) && $stable(PHASE_MODE); endproperty

    a_pd: assert property (p_pd) else $error("power down flag disagrees");
    a_rst_codes: assert property (p_rst_codes) else $error("bad reset codes");
    a_rst_phase: assert property (p_rst_phase) else $error("bad reset phase");
    a_buf: assert property (p_buf) else $error("buffer enable moved");
    a_phase: assert property (p_phase) else $error("phase moved");
    a_dac: assert property (p_dac) else $error("codes moved");
    a_dout_hold: assert property (p_dout_hold) else $error("serial out moved");
    a_frame_hold: assert property (p_frame_hold) else $error("executed mid frame");

    c_phase: cover property ($rose(PHASE_MODE));
    c_down: cover property ($rose(POWER_DOWN));
    c_load: cover property ($fell(LOAD_OUTPUTS_N));
endmodule

bind ocdp_command_port ocdp_command_port_asserts ocdp_command_port_asserts_inst
(
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .CS_N(CS_N), .LOAD_OUTPUTS_N(LOAD_OUTPUTS_N),
    .DOUT(DOUT), .DAC_CODE(DAC_CODE), .BUF_EN(BUF_EN), .POWER_DOWN(POWER_DOWN),
    .PHASE_MODE(PHASE_MODE)
);

// File: dv/ocdp_host.sv
// Host model driving the serial command link of the DAC port
`timescale 1ns/10ps
module ocdp_host
(
    output logic      SCLK,
    output logic      CS_N,
    output logic      DIN,
    input  wire logic DOUT
);
    logic [15:0] rd_hi;
    logic [15:0] rd_lo;

    initial
    begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        DIN  = 1'b0;
    end

    // Noise clocks the link with select high; the device has to ignore it.
    // Keep leaves select low so the next word extends the frame, as a chain does.
    task automatic send(input logic [15:0] word, input logic noise, input logic keep);
        int i;
        if (noise)
        begin
            repeat (4)
            begin
                #6 SCLK = ~SCLK;
                DIN = ~DIN;
            end
        end
        #3 CS_N = 1'b0;
        #7;
        for (i = 15; i >= 0; i--)
        begin
            DIN = word[i];
            #1 SCLK = 1'b1;
            #3 rd_hi[i] = DOUT;
            #3 SCLK = 1'b0;
            #5 rd_lo[i] = DOUT;
        end
        #6;
        if (!keep)
        begin
            CS_N = 1'b1;
            DIN  = ~DIN;
            #50;
        end
    endtask
endmodule

// File: dv/testbench.sv
// Self-checking bench for the octal DAC serial command port
`timescale 1ns/10ps
module testbench;
    logic                  clk;
    logic                  rst_n;
    logic                  load_n;
    logic                  sclk;
    logic                  cs_n;
    logic                  din;
    logic                  dout;
    logic                  power_down;
    logic                  phase_mode;
    logic [7:0]            buf_en;
    ocdp_pkg::ocdp_codes_t dac_code;
    ocdp_pkg::ocdp_codes_t exp_in;
    ocdp_pkg::ocdp_codes_t exp_out;
    logic [7:0]            exp_buf;
    logic                  exp_ph;
    logic [15:0]           prev;
    logic [15:0]           w_far;
    int                    fail_count;
    int                    n_checks;
    int                    cycles = 0;
    int                    i;

    ocdp_command_port ocdp_command_port_inst
    (
        .CLK_SYS(clk), .RSTN(rst_n), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
        .LOAD_OUTPUTS_N(load_n), .DOUT(dout), .DAC_CODE(dac_code), .BUF_EN(buf_en),
        .POWER_DOWN(power_down), .PHASE_MODE(phase_mode)
    );
    ocdp_host ocdp_host_inst
    (
        .SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // A run of about a thousand cycles; five thousand means a hang
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            report_and_stop;
        end
    end

    task automatic report_and_stop;
        if (fail_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] expv);
        n_checks++;
        if (seen !== expv)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
        end
    endtask

    task automatic check_state;
        check("dac_code", dac_code, exp_out);
        check("buf_en", 64'(buf_en), 64'(exp_buf));
        check("power_down", 64'(power_down), 64'(exp_buf == 8'h00));
        check("phase_mode", 64'(phase_mode), 64'(exp_ph));
    endtask

    // One frame, then the expected effect and the echo of the frame before it
    task automatic cmd(input logic [2:0] addr, input ocdp_pkg::ocdp_cmd_t code,
                       input logic [7:0] data, input logic noise);
        logic [15:0] w;
        w = {data[1:0], addr, code, data};
        ocdp_host_inst.send(w, noise, 1'b0);
        check("dout_lo", 64'(ocdp_host_inst.rd_lo), 64'(prev));
        if (exp_ph)
            check("dout_hi", 64'(ocdp_host_inst.rd_hi), 64'(prev));
        else
            check("dout_hi", 64'(ocdp_host_inst.rd_hi[14:0]), 64'(prev[15:1]));
        prev = w;
        case (code)
            ocdp_pkg::CMD_CLEAR:
            begin
                exp_in  = 64'h0;
                exp_out = 64'h0;
                exp_buf = 8'hff;
            end
            ocdp_pkg::CMD_SHUTDOWN: exp_buf = data;
            ocdp_pkg::CMD_PHASE:
            begin
                exp_ph  = addr[2];
                exp_out = exp_in;
            end
            ocdp_pkg::CMD_LOAD_ALL:
            begin
                exp_out = {8{data}};
                exp_buf = 8'hff;
            end
            ocdp_pkg::CMD_LOAD_INPUT: exp_in[addr] = data;
            ocdp_pkg::CMD_LOAD_BOTH:
            begin
                exp_in[addr]  = data;
                exp_out[addr] = data;
                exp_buf       = 8'hff;
            end
            ocdp_pkg::CMD_LOAD_OUTPUTS: exp_out = exp_in;
            default: exp_buf = exp_buf;
        endcase
        if (!load_n)
            exp_out = exp_in;
        repeat (6) @(posedge clk);
        #1;
        check_state;
    endtask

    initial
    begin
        rst_n      = 1'b0;
        load_n     = 1'b1;
        fail_count = 0;
        n_checks   = 0;
        exp_in     = 64'h0;
        exp_out    = 64'h0;
        exp_buf    = 8'hff;
        exp_ph     = 1'b0;
        prev       = 16'h0;
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check_state;
        for (i = 0; i < 8; i++)
            cmd(3'(i), ocdp_pkg::CMD_LOAD_INPUT, 8'(8'h1f + 8'(i) * 8'h21), 1'(i));
        cmd(3'h0, ocdp_pkg::CMD_LOAD_OUTPUTS, 8'h00, 1'b0);
        cmd(3'h3, ocdp_pkg::CMD_LOAD_BOTH, 8'h5a, 1'b0);
        cmd(3'h5, ocdp_pkg::CMD_NOP, 8'hff, 1'b1);
        cmd(3'h2, ocdp_pkg::CMD_SHUTDOWN, 8'h0f, 1'b0);
        cmd(3'h2, ocdp_pkg::CMD_LOAD_INPUT, 8'h3c, 1'b0);
        cmd(3'h0, ocdp_pkg::CMD_LOAD_OUTPUTS, 8'h00, 1'b0);
        cmd(3'h1, ocdp_pkg::CMD_SHUTDOWN, 8'h00, 1'b1);
        cmd(3'h6, ocdp_pkg::CMD_LOAD_ALL, 8'hc3, 1'b0);
        cmd(3'h4, ocdp_pkg::CMD_PHASE, 8'h00, 1'b0);
        cmd(3'h6, ocdp_pkg::CMD_LOAD_BOTH, 8'h99, 1'b1);
        cmd(3'h0, ocdp_pkg::CMD_SHUTDOWN, 8'haa, 1'b0);
        cmd(3'h3, ocdp_pkg::CMD_PHASE, 8'h00, 1'b0);
        // Two-word chain: the far word must pass out and must not execute here
        w_far = {2'b00, 3'h2, ocdp_pkg::CMD_LOAD_BOTH, 8'h77};
        ocdp_host_inst.send(w_far, 1'b0, 1'b1);
        check("chain_lo", 64'(ocdp_host_inst.rd_lo), 64'(prev));
        prev = w_far;
        cmd(3'h5, ocdp_pkg::CMD_NOP, 8'h00, 1'b0);
        cmd(3'h7, ocdp_pkg::CMD_LOAD_INPUT, 8'h44, 1'b0);
        load_n = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        exp_out = exp_in;
        check_state;
        cmd(3'h1, ocdp_pkg::CMD_LOAD_INPUT, 8'h66, 1'b0);
        load_n = 1'b1;
        cmd(3'h0, ocdp_pkg::CMD_CLEAR, 8'hff, 1'b1);
        cmd(3'h0, ocdp_pkg::CMD_LOAD_OUTPUTS, 8'h00, 1'b0);
        // Leave non-default state behind, then reset in mid-run
        cmd(3'h7, ocdp_pkg::CMD_PHASE, 8'h00, 1'b0);
        cmd(3'h4, ocdp_pkg::CMD_LOAD_ALL, 8'h81, 1'b0);
        cmd(3'h0, ocdp_pkg::CMD_SHUTDOWN, 8'h3c, 1'b0);
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        rst_n   = 1'b1;
        exp_in  = 64'h0;
        exp_out = 64'h0;
        exp_buf = 8'hff;
        exp_ph  = 1'b0;
        prev    = 16'h0;
        repeat (4) @(posedge clk);
        #1;
        check_state;
        cmd(3'h1, ocdp_pkg::CMD_LOAD_BOTH, 8'h2d, 1'b0);
        report_and_stop;
    end
endmodule

// File: hw/ocdp_command_port.sv
// Serial command port of an eight-channel 8-bit DAC
`timescale 1ns/10ps

// What this block does
// - Power-up clears shift logic and all input and output codes to zero.
// - Serial output phase defaults to falling-edge mode after power-up.
// - Frames are 16 bits MSB first, as nibbles plus byte or one word.
// - First two bits ignored; then 3-bit address, 3-bit command, 8-bit payload.
// - With select low, data in is shifted on each serial clock rise.
// - Serial out shows each bit 16 clocks later, on fall or rise per phase.
// - Select high: clock and data ignored, serial out holds, never floats.
// - Command 000 only passes data through; no register changes.
// - Command 001 clears all input and output registers.
// - Command 010 disables buffers whose payload bit is zero; zero means full down.
// - Shutdown left only by power-up, clear, load-all, load-both or a command 010 with nonzero payload.
// - Command 011 sets output phase from the top address bit.
// - Command 100 writes payload into all eight output registers.
// - Command 101 writes payload into addressed input register only.
// - Command 110 writes payload into addressed input and output registers.
// - Command 111 copies every input register into its output register.
// - Active-low load pin copies inputs to outputs on CLK_SYS after a two-stage sync.
// - Frame is decoded and executed when select rises.
// - While load pin is low, outputs follow their input registers.
// - Phase commands also copy inputs to outputs; phase persists.
module ocdp_command_port
(
    input  wire logic                      CLK_SYS,
    input  wire logic                      RSTN,
    input  wire logic                      SCLK,
    input  wire logic                      CS_N,
    input  wire logic                      DIN,
    input  wire logic                      LOAD_OUTPUTS_N,
    output logic                           DOUT,
    output ocdp_pkg::ocdp_codes_t          DAC_CODE,
    output logic [ocdp_pkg::CHANNELS-1:0]  BUF_EN,
    output logic                           POWER_DOWN,
    output logic                           PHASE_MODE
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if ($bits(ocdp_pkg::ocdp_frame_t) != ocdp_pkg::FRAME_BITS)
    begin : g_bad_frame
        $error("Frame fields do not add up to the frame length");
    end

    if (ocdp_pkg::CHANNELS != (1 << ocdp_pkg::ADDR_W))
    begin : g_bad_chan
        $error("Channel count must match the address width");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    ocdp_pkg::ocdp_rise_t  rise;
    ocdp_pkg::ocdp_rise_t  next_rise;
    ocdp_pkg::ocdp_fall_t  fall;
    ocdp_pkg::ocdp_fall_t  next_fall;
    ocdp_pkg::ocdp_sys_t   sys;
    ocdp_pkg::ocdp_sys_t   next_sys;
    ocdp_pkg::ocdp_frame_t frame;
    logic                  cs_high;
    logic                  cs_rose;
    logic                  load_low;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Same code on every channel; clear and load-all share it
    function automatic ocdp_pkg::ocdp_codes_t fill_codes
    (
        input logic [ocdp_pkg::CODE_W-1:0] code
    );
        ocdp_pkg::ocdp_codes_t codes;
        codes = '0;
        for (int i = 0; i < ocdp_pkg::CHANNELS; i++)
        begin
            codes[i] = code;
        end
        return codes;
    endfunction

    // ----------------------------------------------------------------
    // Serial clock, rising edge: shift register and mode 1 output
    // ----------------------------------------------------------------
    // SCLK need not run outside frames, so nothing here may count on
    // an edge after select rises; execution is left to CLK_SYS.
    always_comb
    begin
        next_rise = rise;
        if (!CS_N)
        begin
            // Old MSB leaves as the new bit enters: a 16-clock lag
            next_rise.rise_q = rise.shift[ocdp_pkg::FRAME_BITS-1];
            next_rise.shift  = {rise.shift[ocdp_pkg::FRAME_BITS-2:0], DIN};
        end
    end

    always_ff @(posedge SCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rise.shift  <= ocdp_pkg::SHIFT_RST;
            rise.rise_q <= 1'b0;
        end
        else
        begin
            rise <= next_rise;
        end
    end

    // ----------------------------------------------------------------
    // Serial clock, falling edge: mode 0 output half a clock later
    // ----------------------------------------------------------------
    always_comb
    begin
        next_fall = fall;
        if (!CS_N)
        begin
            next_fall.fall_q = rise.rise_q;
        end
    end

    always_ff @(negedge SCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            fall.fall_q <= 1'b0;
        end
        else
        begin
            fall <= next_fall;
        end
    end

    // Both copies hold while select is high, so the pin never floats
    // and keeps its last level; the phase bit only moves between frames.
    assign DOUT = sys.phase ? rise.rise_q : fall.fall_q;

    // ----------------------------------------------------------------
    // System domain: select tracking and frame decode
    // ----------------------------------------------------------------
    assign cs_high  = sys.cs_sync[1];
    assign load_low = !sys.ld_sync[1];
    assign cs_rose  = cs_high && (sys.link == ocdp_pkg::LINK_FRAME);

    // The shift register is read here only after synchronised select
    // is high, when SCLK is parked and the word is stable.
    assign frame = ocdp_pkg::ocdp_frame_t'(rise.shift);

    always_comb
    begin
        next_sys = sys;

        // Two-stage synchronisers; only stage 1 reads stage 0
        next_sys.cs_sync = {sys.cs_sync[0], CS_N};
        next_sys.ld_sync = {sys.ld_sync[0], LOAD_OUTPUTS_N};

        case (sys.link)
            ocdp_pkg::LINK_IDLE:
            begin
                if (!cs_high)
                begin
                    next_sys.link = ocdp_pkg::LINK_FRAME;
                end
            end
            ocdp_pkg::LINK_FRAME:
            begin
                if (cs_high)
                begin
                    next_sys.link = ocdp_pkg::LINK_IDLE;
                end
            end
            default:
            begin
                next_sys.link = ocdp_pkg::LINK_IDLE;
            end
        endcase

        // Short frames are not detected: the last 16 bits shifted
        // decide, as the ignored top bits carry no meaning.
        if (cs_rose)
        begin
            case (frame.command_code)
                ocdp_pkg::CMD_NOP:
                begin
                    next_sys.link = ocdp_pkg::LINK_IDLE;
                end
                ocdp_pkg::CMD_CLEAR:
                begin
                    next_sys.in_reg  = fill_codes(ocdp_pkg::CODE_RST);
                    next_sys.out_reg = fill_codes(ocdp_pkg::CODE_RST);
                    next_sys.buf_en  = ocdp_pkg::BUF_EN_ALL;
                end
                ocdp_pkg::CMD_SHUTDOWN:
                begin
                    next_sys.buf_en = frame.payload_byte;
                end
                ocdp_pkg::CMD_PHASE:
                begin
                    next_sys.phase   = frame.channel_address[ocdp_pkg::ADDR_TOP];
                    next_sys.out_reg = sys.in_reg;
                end
                ocdp_pkg::CMD_LOAD_ALL:
                begin
                    next_sys.out_reg = fill_codes(frame.payload_byte);
                    next_sys.buf_en  = ocdp_pkg::BUF_EN_ALL;
                end
                ocdp_pkg::CMD_LOAD_INPUT:
                begin
                    next_sys.in_reg[frame.channel_address] = frame.payload_byte;
                end
                ocdp_pkg::CMD_LOAD_BOTH:
                begin
                    next_sys.in_reg[frame.channel_address]  = frame.payload_byte;
                    next_sys.out_reg[frame.channel_address] = frame.payload_byte;
                    next_sys.buf_en = ocdp_pkg::BUF_EN_ALL;
                end
                ocdp_pkg::CMD_LOAD_OUTPUTS:
                begin
                    next_sys.out_reg = sys.in_reg;
                end
                default:
                begin
                    next_sys.buf_en = sys.buf_en;
                end
            endcase
        end

        // Transparency is applied last so outputs track an input
        // written in the same cycle; the pin pays two cycles of sync.
        if (load_low)
        begin
            next_sys.out_reg = next_sys.in_reg;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            sys.cs_sync <= ocdp_pkg::SYNC_RST;
            sys.ld_sync <= ocdp_pkg::SYNC_RST;
            sys.link    <= ocdp_pkg::LINK_IDLE;
            for (int i = 0; i < ocdp_pkg::CHANNELS; i++)
            begin
                sys.in_reg[i]  <= ocdp_pkg::CODE_RST;
                sys.out_reg[i] <= ocdp_pkg::CODE_RST;
            end
            sys.buf_en  <= ocdp_pkg::BUF_EN_RST;
            sys.phase   <= ocdp_pkg::PHASE_RST;
        end
        else
        begin
            sys <= next_sys;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign DAC_CODE   = sys.out_reg;
    assign BUF_EN     = sys.buf_en;
    assign POWER_DOWN = (sys.buf_en == '0);
    assign PHASE_MODE = sys.phase;

endmodule

// File: hw/ocdp_pkg.sv
// Constants and types shared by the octal DAC serial command port
package ocdp_pkg;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int CHANNELS   = 8;
    localparam int CODE_W     = 8;
    localparam int ADDR_W     = 3;
    localparam int ADDR_TOP   = 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [CODE_W-1:0]     CODE_RST   = 8'h00;
    localparam logic [CHANNELS-1:0]   BUF_EN_RST = 8'hff;
    localparam logic [CHANNELS-1:0]   BUF_EN_ALL = 8'hff;
    localparam logic                  PHASE_RST  = 1'b0;
    localparam logic [FRAME_BITS-1:0] SHIFT_RST  = 16'h0000;
    localparam logic [1:0]            SYNC_RST   = 2'h3;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NOP          = 3'b000,
        CMD_CLEAR        = 3'b001,
        CMD_SHUTDOWN     = 3'b010,
        CMD_PHASE        = 3'b011,
        CMD_LOAD_ALL     = 3'b100,
        CMD_LOAD_INPUT   = 3'b101,
        CMD_LOAD_BOTH    = 3'b110,
        CMD_LOAD_OUTPUTS = 3'b111
    } ocdp_cmd_t;

    // Frame as shifted in, most significant bit first
    typedef struct packed {
        logic [1:0]        ignored;
        logic [ADDR_W-1:0] channel_address;
        ocdp_cmd_t         command_code;
        logic [CODE_W-1:0] payload_byte;
    } ocdp_frame_t;

    typedef logic [CHANNELS-1:0][CODE_W-1:0] ocdp_codes_t;

    // ----------------------------------------------------------------
    // Chip-select tracking and register state in the system domain
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        LINK_IDLE  = 1'b0,
        LINK_FRAME = 1'b1
    } ocdp_link_t;

    typedef struct packed {
        logic [1:0]          cs_sync;
        logic [1:0]          ld_sync;
        ocdp_link_t          link;
        ocdp_codes_t         in_reg;
        ocdp_codes_t         out_reg;
        logic [CHANNELS-1:0] buf_en;
        logic                phase;
    } ocdp_sys_t;

    // ----------------------------------------------------------------
    // Serial-clock domain state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [FRAME_BITS-1:0] shift;
        logic                  rise_q;
    } ocdp_rise_t;

    typedef struct packed {
        logic fall_q;
    } ocdp_fall_t;

endpackage
